/* File: spc_ctrl2.sv */
// Purpose: control-two register of a serial port with its transmitter and pin logic
// Assumes: APB master, one 250 MHz clock, pins synchronous to it
// Notes:   pin output enable is high while the block drives the pin
`default_nettype none
module spc_ctrl2 import spc_pkg::*; (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // serial pins
  input  wire logic        serial_in_i,
  input  wire logic        serial_out_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  output logic             tx_pin_owned_o,
  output logic             rx_pin_owned_o,
  // interrupt request
  output logic             irq_o
);
  // ******************************************
  // state and decode
  // ******************************************
  spc_state_s s;
  spc_state_s n;
  logic       setup;
  logic       acc;
  logic       wr;
  logic       ctrl_wr;
  logic       data_wr;
  logic       data_rd;
  logic       tx_done;
  logic       loop_int;
  logic       loop_one;
  logic       rx_line;
  logic       rx_dv;
  logic [8:0] rx_dat;
  logic       rx_msb;
  logic       rx_idle;
  logic       stby;
  logic       wake;
  logic [3:0] frm;
  logic       brk_go;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign setup   = psel_i & ~penable_i;
  assign acc     = psel_i & penable_i & s.pready;
  assign wr      = acc & pwrite_i;
  assign ctrl_wr = wr & hit(paddr_i, SPC_OFF_CTRL);
  assign data_wr = wr & hit(paddr_i, SPC_OFF_DATA);
  assign data_rd = acc & ~pwrite_i & hit(paddr_i, SPC_OFF_DATA);
  assign frm     = s.cfg[SPC_LONG_FRAME] ? SPC_FRM_LONG : SPC_FRM_SHORT;
  assign brk_go  = s.bpend | (s.ctrl[SPC_BREAK_QUEUE] & s.ctrl[SPC_TX_ON]);
  // status view: idle when buffer empty and nothing queued or sending
  assign tx_done = s.txe & (s.txs == SPC_TX_IDLE) & ~s.ipend & ~s.bpend;

  // ******************************************
  // receive path and wakeup
  // ******************************************
  assign loop_int = s.cfg[SPC_LOOP_MODE] & ~s.cfg[SPC_RX_SOURCE_SEL];
  assign loop_one = s.cfg[SPC_LOOP_MODE] & s.cfg[SPC_RX_SOURCE_SEL];
  assign rx_line  = loop_int ? s.out : (loop_one ? serial_out_in_i : serial_in_i);
  assign stby     = s.ctrl[SPC_RX_STANDBY];
  assign wake     = stby & (s.cfg[SPC_STANDBY_EXIT] ? (rx_dv & rx_msb) : rx_idle);

  spc_rx u_rx (
    .sys_clk_i    (sys_clk_i),
    .reset_n_i    (reset_n_i),
    .enable_i     (s.ctrl[SPC_RX_ON]),
    .long_frame_i (s.cfg[SPC_LONG_FRAME]),
    .line_i       (rx_line),
    .data_valid_o (rx_dv),
    .data_o       (rx_dat),
    .data_msb_o   (rx_msb),
    .idle_o       (rx_idle)
  );

  // ******************************************
  // next state
  // ******************************************
  always_comb begin
    n         = s;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    // apb: answer prepared in setup, zero wait states
    if (setup) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      if (hit(paddr_i, SPC_OFF_CFG)) begin
        n.prdata[4:0] = s.cfg;
      end else if (hit(paddr_i, SPC_OFF_CTRL)) begin
        n.prdata[7:0] = s.ctrl;
      end else if (hit(paddr_i, SPC_OFF_STAT)) begin
        n.prdata[7:4] = {s.txe, tx_done, s.rxf, s.quiet};
      end else if (hit(paddr_i, SPC_OFF_DATA)) begin
        n.prdata[8:0] = s.rbuf;
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (wr && hit(paddr_i, SPC_OFF_CFG)) begin
      n.cfg = pwdata_i[4:0];
    end
    // hardware wakeup clears standby; a software write in the same cycle wins
    if (wake) begin
      n.ctrl[SPC_RX_STANDBY] = 1'b0;
    end
    if (ctrl_wr) begin
      n.ctrl = pwdata_i[7:0];
    end

    // transmitter
    unique case (s.txs)
      SPC_TX_IDLE: begin
        if (s.ipend) begin
          n.ipend = 1'b0;
          n.shf   = SPC_IDLE_FRM;
          n.nbits = frm;
          n.bcnt  = SPC_BIT_CYC - 16'h0001;
          n.txs   = SPC_TX_SEND;
        end else if (brk_go) begin
          n.bpend = 1'b0;
          n.shf   = SPC_BREAK_FRM;
          n.nbits = frm;
          n.bcnt  = SPC_BIT_CYC - 16'h0001;
          n.txs   = SPC_TX_SEND;
        end else if (!s.txe) begin
          // data already accepted still goes out after tx_on falls
          n.txe   = 1'b1;
          n.shf   = s.cfg[SPC_LONG_FRAME] ? {1'b1, s.tbuf, 1'b0}
                                          : {2'b11, s.tbuf[7:0], 1'b0};
          n.nbits = frm;
          n.bcnt  = SPC_BIT_CYC - 16'h0001;
          n.txs   = SPC_TX_SEND;
        end
      end
      SPC_TX_SEND: begin
        if (s.bcnt != 16'h0000) begin
          n.bcnt = s.bcnt - 16'h0001;
        end else begin
          n.bcnt  = SPC_BIT_CYC - 16'h0001;
          n.shf   = {1'b1, s.shf[10:1]};
          n.nbits = s.nbits - 4'h1;
          if (s.nbits == 4'h1) begin
            n.txs = SPC_TX_IDLE;
          end
        end
      end
    endcase

    // queue requests set after the load clears them, so none is lost
    if (ctrl_wr && !s.ctrl[SPC_TX_ON] && pwdata_i[SPC_TX_ON]) begin
      n.ipend = 1'b1;
    end
    if (ctrl_wr && !s.ctrl[SPC_BREAK_QUEUE] && pwdata_i[SPC_BREAK_QUEUE]
        && pwdata_i[SPC_TX_ON]) begin
      n.bpend = 1'b1;
    end
    // data writes are accepted only while the transmitter is on
    if (data_wr && s.ctrl[SPC_TX_ON]) begin
      n.tbuf = pwdata_i[8:0];
      n.txe  = 1'b0;
    end

    // receive flags: read of data clears, a new event in the same cycle wins
    if (data_rd) begin
      n.rxf   = 1'b0;
      n.quiet = 1'b0;
    end
    if (rx_dv && (!stby || (s.cfg[SPC_STANDBY_EXIT] && rx_msb))) begin
      n.rxf  = 1'b1;
      n.rbuf = rx_dat;
    end
    if (rx_idle && !stby) begin
      n.quiet = 1'b1;
    end

    // interrupt request
    n.irq = |({s.txe, tx_done, s.rxf, s.quiet} & s.ctrl[7:4]);

    // pins
    n.out   = (n.txs == SPC_TX_SEND) ? n.shf[0] : 1'b1;
    n.txown = (s.ctrl[SPC_TX_ON] | (s.txs == SPC_TX_SEND) | s.ipend | s.bpend | ~s.txe)
              & ~loop_int;
    n.oe    = n.txown & (~loop_one | s.cfg[SPC_SINGLE_WIRE_DIR]);
    n.rxown = s.ctrl[SPC_RX_ON] & ~s.cfg[SPC_LOOP_MODE];
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s      <= '0;
      s.ctrl <= SPC_CTRL_RST;
      s.cfg  <= SPC_CFG_RST;
      s.txe  <= 1'b1;
      s.out  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata_o        = s.prdata;
  assign pready_o        = s.pready;
  assign pslverr_o       = s.pslverr;
  assign serial_out_o    = s.out;
  assign serial_out_oe_o = s.oe;
  assign tx_pin_owned_o  = s.txown;
  assign rx_pin_owned_o  = s.rxown;
  assign irq_o           = s.irq;

  // ******************************************
  // assertions
  // ******************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_tx_off_busy;
    ctrl_wr && !pwdata_i[SPC_TX_ON] && s.txs == SPC_TX_SEND;
  endsequence
  sequence s_tx_restart;
    ctrl_wr && pwdata_i[SPC_TX_ON] && !s.ctrl[SPC_TX_ON];
  endsequence
  sequence s_brk_load;
    s.txs == SPC_TX_IDLE && !s.ipend && brk_go;
  endsequence
  sequence s_data_load;
    s.txs == SPC_TX_IDLE && !s.ipend && !brk_go && !s.txe && !data_wr;
  endsequence

  a_apb_ready: assert property (setup |=> pready_o ##1 !pready_o)
    else $error("apb access not answered in one cycle");
  a_irq_tx_empty: assert property (s.ctrl[7] && s.txe |=> irq_o)
    else $error("buffer-empty request missing");
  a_irq_tx_done: assert property (s.ctrl[6] && tx_done |=> irq_o)
    else $error("done request missing");
  a_irq_rx_full: assert property (s.ctrl[5] && s.rxf |=> irq_o)
    else $error("receive-full request missing");
  a_irq_quiet: assert property (s.ctrl[4] && s.quiet |=> irq_o)
    else $error("idle-line request missing");
  a_irq_none: assert property
    (!(|({s.txe, tx_done, s.rxf, s.quiet} & s.ctrl[7:4])) |=> !irq_o)
    else $error("request without enabled source");
  a_pin_normal: assert property
    (!s.cfg[SPC_LOOP_MODE] && s.ctrl[SPC_TX_ON] |=> serial_out_oe_o)
    else $error("output pin not driven");
  a_pin_loop: assert property (loop_int |=> !serial_out_oe_o && !tx_pin_owned_o)
    else $error("pin driven in loopback");
  a_pin_one_wire: assert property
    (loop_one && s.ctrl[SPC_TX_ON] |=> serial_out_oe_o == $past(s.cfg[SPC_SINGLE_WIRE_DIR]))
    else $error("single-wire direction ignored");
  a_idle_queue: assert property ((s_tx_off_busy ##[1:64] s_tx_restart) |=> s.ipend)
    else $error("idle character not queued");
  a_pin_hold: assert property
    (!loop_int && !s.ctrl[SPC_TX_ON] && s.txs == SPC_TX_SEND |=> tx_pin_owned_o)
    else $error("pin released while sending");
  a_rx_release: assert property (!s.ctrl[SPC_RX_ON] |=> !rx_pin_owned_o)
    else $error("input pin kept while receiver off");
  a_wake_clear: assert property (wake && !ctrl_wr |=> !s.ctrl[SPC_RX_STANDBY])
    else $error("standby not cleared on wakeup");
  a_break_len: assert property
    (s_brk_load |=> s.shf == SPC_BREAK_FRM && s.nbits == $past(frm))
    else $error("break frame length wrong");
  a_break_low: assert property (s_brk_load |=> !serial_out_o [*8])
    else $error("break not held low");
  a_buf_empty: assert property (s_data_load |=> s.txe && s.txs == SPC_TX_SEND)
    else $error("buffer-empty not set on transfer");
endmodule // spc_ctrl2
`default_nettype wire

/* File: spc_pkg.sv */
// Purpose: constants and state types of the serial control-two block
// Assumes: 32-bit APB, one clock at 250 MHz
// Notes:   offsets are byte addresses of aligned words
`default_nettype none
package spc_pkg;
  // ******************************************
  // register map
  // ******************************************
  localparam logic [7:0] SPC_OFF_CFG  = 8'h00;
  localparam logic [7:0] SPC_OFF_CTRL = 8'h04;
  localparam logic [7:0] SPC_OFF_STAT = 8'h08;
  localparam logic [7:0] SPC_OFF_DATA = 8'h0c;
  localparam logic [7:0] SPC_CTRL_RST = 8'h00;
  localparam logic [4:0] SPC_CFG_RST  = 5'h00;
  // control-two fields
  localparam int SPC_TX_EMPTY_IRQ_EN   = 7;
  localparam int SPC_TX_DONE_IRQ_EN    = 6;
  localparam int SPC_RX_FULL_IRQ_EN    = 5;
  localparam int SPC_LINE_QUIET_IRQ_EN = 4;
  localparam int SPC_TX_ON             = 3;
  localparam int SPC_RX_ON             = 2;
  localparam int SPC_RX_STANDBY        = 1;
  localparam int SPC_BREAK_QUEUE       = 0;
  // configuration fields
  localparam int SPC_LOOP_MODE         = 0;
  localparam int SPC_RX_SOURCE_SEL     = 1;
  localparam int SPC_SINGLE_WIRE_DIR   = 2;
  localparam int SPC_STANDBY_EXIT      = 3;
  localparam int SPC_LONG_FRAME        = 4;
  // ******************************************
  // timing
  // ******************************************
  localparam int SPC_CLK_NS = 4;
  localparam int SPC_BIT_NS = 64;
  localparam logic [15:0] SPC_BIT_CYC  = 16'(SPC_BIT_NS / SPC_CLK_NS);
  localparam logic [15:0] SPC_HALF_CYC = 16'(SPC_BIT_NS / SPC_CLK_NS / 2);
  localparam logic [3:0] SPC_FRM_SHORT = 4'ha;
  localparam logic [3:0] SPC_FRM_LONG  = 4'hb;
  localparam logic [10:0] SPC_IDLE_FRM  = 11'h7ff;
  localparam logic [10:0] SPC_BREAK_FRM = 11'h000;
  // ******************************************
  // state types
  // ******************************************
  typedef enum logic [0:0] {SPC_TX_IDLE, SPC_TX_SEND} spc_tx_e;
  typedef enum logic [0:0] {SPC_RX_IDLE, SPC_RX_BUSY} spc_rx_e;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [4:0]  cfg;
    logic [8:0]  tbuf;
    logic        txe;
    logic [10:0] shf;
    logic [3:0]  nbits;
    logic [15:0] bcnt;
    spc_tx_e     txs;
    logic        ipend;
    logic        bpend;
    logic        rxf;
    logic        quiet;
    logic [8:0]  rbuf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        out;
    logic        oe;
    logic        txown;
    logic        rxown;
  } spc_state_s;
  typedef struct packed {
    spc_rx_e     rxs;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [9:0]  shf;
    logic [3:0]  qcnt;
    logic        armed;
    logic        dv;
    logic [8:0]  dat;
    logic        msb;
    logic        idle;
  } spc_rx_s;
endpackage
`default_nettype wire

/* File: spc_rx.sv */
// Purpose: serial receiver with idle-line detection
// Assumes: line is synchronous to sys_clk_i
// Notes:   no framing or noise checks; stop bit is not checked
`default_nettype none
module spc_rx import spc_pkg::*; (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       enable_i,
  input  wire logic       long_frame_i,
  input  wire logic       line_i,
  // results
  output logic            data_valid_o,
  output logic [8:0]      data_o,
  output logic            data_msb_o,
  output logic            idle_o
);
  spc_rx_s r;
  spc_rx_s n;
  logic [3:0] frm;
  logic [9:0] nx;

  assign frm = long_frame_i ? SPC_FRM_LONG : SPC_FRM_SHORT;
  assign nx  = {line_i, r.shf[9:1]};

  always_comb begin
    n      = r;
    n.dv   = 1'b0;
    n.idle = 1'b0;
    unique case (r.rxs)
      SPC_RX_IDLE: begin
        if (!line_i) begin
          n.rxs  = SPC_RX_BUSY;
          n.cnt  = SPC_HALF_CYC;
          n.bitn = 4'h0;
          n.qcnt = 4'h0;
        end else if (r.cnt == 16'h0000) begin
          n.cnt = SPC_BIT_CYC - 16'h0001;
          // idle reported once per received character
          if (r.qcnt != 4'hf) begin
            n.qcnt = r.qcnt + 4'h1;
          end
          if (r.armed && (r.qcnt + 4'h1 == frm)) begin
            n.idle  = 1'b1;
            n.armed = 1'b0;
          end
        end else begin
          n.cnt = r.cnt - 16'h0001;
        end
      end
      SPC_RX_BUSY: begin
        if (r.cnt != 16'h0000) begin
          n.cnt = r.cnt - 16'h0001;
        end else begin
          n.cnt  = SPC_BIT_CYC - 16'h0001;
          n.bitn = r.bitn + 4'h1;
          if (r.bitn == 4'h0) begin
            // a glitch shorter than half a bit is no start
            if (line_i) begin
              n.rxs = SPC_RX_IDLE;
            end
          end else begin
            n.shf = nx;
            if (r.bitn == frm - 4'h1) begin
              n.rxs   = SPC_RX_IDLE;
              n.dv    = 1'b1;
              n.msb   = nx[8];
              n.dat   = long_frame_i ? nx[8:0] : {1'b0, nx[8:1]};
              n.armed = 1'b1;
            end
          end
        end
      end
    endcase
    if (!enable_i) begin
      n.rxs   = SPC_RX_IDLE;
      n.armed = 1'b0;
      n.qcnt  = 4'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign data_valid_o = r.dv;
  assign data_o       = r.dat;
  assign data_msb_o   = r.msb;
  assign idle_o       = r.idle;
endmodule // spc_rx
`default_nettype wire

/* File: spc_remote.sv */
// Purpose: far-side serial device: sends 8-bit frames, captures and times the line
// Assumes: 16 clocks a bit, lsb first, one stop bit
// Notes:   break frames are captured as zero characters
`default_nettype none
module spc_remote (
  // clock
  input  wire logic clk_i,
  // line from the block
  input  wire logic line_i,
  input  wire logic oe_i,
  // line to the block
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // shortest break: ten bit times of sixteen clocks
  localparam int BRK_MIN = 160;
  logic [7:0] got;
  int         run;
  int         maxrun;
  int         brk;
  initial begin
    line_o = 1'b1;
    got    = 8'h00;
    run    = 0;
    maxrun = 0;
    brk    = 0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk_i) line_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (16) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask
  // longest low stretch while driven, and a count of whole breaks seen
  always @(posedge clk_i) begin
    if (oe_i === 1'b1 && line_i === 1'b0) run = run + 1;
    else begin
      if (run >= BRK_MIN) brk = brk + 1;
      run = 0;
    end
    if (run > maxrun) maxrun = run;
  end
  // sample mid-bit after a falling start edge
  initial forever begin
    @(posedge clk_i);
    if (oe_i === 1'b1 && line_i === 1'b0) begin
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge clk_i);
        got[i] = line_i;
      end
      repeat (16) @(posedge clk_i);
    end
  end
endmodule // spc_remote
`default_nettype wire

/* File: test_spc_ctrl2.sv */
// Purpose: self-checking bench of the control-two block
// Assumes: zero-wait apb answer, 16-clock bit time
// Notes:   table rows cover enables and pin ownership
`default_nettype none
module test_spc_ctrl2;
  import spc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] cfg;
    logic       irq;
    logic       oe;
    logic       rxo;
  } spc_row_s;
  spc_row_s rows [8] = '{'{8'h80, 5'h00, 1'b1, 1'b0, 1'b0}, '{8'h40, 5'h00, 1'b1, 1'b0, 1'b0},
    '{8'h20, 5'h00, 1'b0, 1'b0, 1'b0}, '{8'h10, 5'h00, 1'b0, 1'b0, 1'b0},
    '{8'h0c, 5'h00, 1'b0, 1'b1, 1'b1}, '{8'h0c, 5'h01, 1'b0, 1'b0, 1'b0},
    '{8'h08, 5'h07, 1'b0, 1'b1, 1'b0}, '{8'h08, 5'h03, 1'b0, 1'b0, 1'b0}};
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, slverr;
  logic        rx_line, sout, soe, txo, rxo, irq, wire_lvl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  int          err_total, total_checks;
  assign wire_lvl = soe ? sout : 1'b1;
  spc_ctrl2 u_spc_ctrl2 (.sys_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .serial_in_i(rx_line),
    .serial_out_in_i(wire_lvl), .serial_out_o(sout), .serial_out_oe_o(soe),
    .tx_pin_owned_o(txo), .rx_pin_owned_o(rxo), .irq_o(irq));
  spc_remote u_spc_remote (.clk_i(clk), .line_i(sout), .oe_i(soe), .line_o(rx_line));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    // expected run is about 8000 clocks
    #(4 * 60000);
    err_total++;
    test_done;
  end
  initial begin
    err_total = 0; total_checks = 0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; rv = 32'h0; slverr = 1'b0;
    cyc(4);
    chk(32'({irq, soe}), 32'h0);
    rst_n <= 1'b1;
    rd(SPC_OFF_CTRL);
    chk(rv, 32'(SPC_CTRL_RST));
    rd(SPC_OFF_STAT);
    chk(rv, 32'hc0);
    rd(8'h10);
    chk({rv[30:0], slverr}, 32'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(SPC_OFF_CFG, 32'(rows[i].cfg));
      wr(SPC_OFF_CTRL, 32'(rows[i].ctrl));
      cyc(400);
      rd(SPC_OFF_CTRL);
      chk(rv, 32'(rows[i].ctrl));
      chk(32'({irq, soe, rxo}), 32'({rows[i].irq, rows[i].oe, rows[i].rxo}));
    end
    $display("test rows done");
    wr(SPC_OFF_CFG, 32'h0);
    wr(SPC_OFF_DATA, 32'ha5);
    rd(SPC_OFF_STAT);
    chk(32'(rv[6]), 32'h0);
    cyc(200);
    chk(32'(u_spc_remote.got), 32'ha5);
    rd(SPC_OFF_STAT);
    chk(32'(rv[7:6]), 32'h3);
    wr(SPC_OFF_DATA, 32'h5a);
    wr(SPC_OFF_CTRL, 32'h0);
    cyc(20);
    chk(32'({soe, txo}), 32'h3);
    cyc(300);
    chk(32'({soe, txo}), 32'h0);
    chk(32'(u_spc_remote.got), 32'h5a);
    $display("test transmit done");
    wr(SPC_OFF_CTRL, 32'h08);
    cyc(400);
    wr(SPC_OFF_DATA, 32'hc3);
    wr(SPC_OFF_CTRL, 32'h0);
    wr(SPC_OFF_CTRL, 32'h08);
    cyc(200);
    rd(SPC_OFF_STAT);
    chk(32'(rv[6]), 32'h0);
    cyc(200);
    rd(SPC_OFF_STAT);
    chk(32'(rv[6]), 32'h1);
    $display("test queued idle done");
    for (int k = 0; k < 2; k++) begin
      wr(SPC_OFF_CFG, k ? 32'h10 : 32'h0);
      u_spc_remote.maxrun = 0;
      wr(SPC_OFF_CTRL, 32'h09);
      wr(SPC_OFF_CTRL, 32'h08);
      cyc(400);
      chk(32'(u_spc_remote.maxrun), k ? 32'd176 : 32'd160);
    end
    u_spc_remote.maxrun = 0;
    u_spc_remote.brk = 0;
    wr(SPC_OFF_CTRL, 32'h09);
    cyc(500);
    wr(SPC_OFF_CTRL, 32'h08);
    cyc(400);
    chk(32'(u_spc_remote.brk >= 2), 32'h1);
    chk(32'(u_spc_remote.maxrun), 32'd176);
    $display("test break done");
    wr(SPC_OFF_CFG, 32'h0);
    wr(SPC_OFF_CTRL, 32'h24);
    u_spc_remote.send(8'h3c);
    cyc(40);
    chk(32'(irq), 32'h1);
    rd(SPC_OFF_DATA);
    chk(rv, 32'h3c);
    cyc(3);
    chk(32'(irq), 32'h0);
    cyc(200);
    wr(SPC_OFF_CTRL, 32'h14);
    cyc(3);
    chk(32'(irq), 32'h1);
    $display("test receive done");
    for (int m = 0; m < 2; m++) begin
      wr(SPC_OFF_CFG, m ? 32'h08 : 32'h0);
      wr(SPC_OFF_CTRL, 32'h06);
      u_spc_remote.send(8'h11);
      cyc(40);
      rd(SPC_OFF_CTRL);
      chk(32'(rv[1]), 32'h1);
      if (m) u_spc_remote.send(8'h91);
      cyc(m ? 40 : 300);
      rd(SPC_OFF_CTRL);
      chk(32'(rv[1]), 32'h0);
    end
    $display("test standby done");
    wr(SPC_OFF_CTRL, 32'h8c);
    cyc(20);
    chk(32'({irq, soe, rxo}), 32'h7);
    rst_n <= 1'b0;
    cyc(2);
    chk(32'({irq, soe, txo, rxo, sout}), 32'h1);
    rst_n <= 1'b1;
    rd(SPC_OFF_CTRL);
    chk(rv, 32'(SPC_CTRL_RST));
    rd(SPC_OFF_STAT);
    chk(rv, 32'hc0);
    $display("test mid-run reset done");
    test_done;
  end
endmodule // test_spc_ctrl2
`default_nettype wire
